// >>> verilog/sslc_cfg.svh
/*
  Constants for the supply supervisor low-power control block.
  Assumes a 25 MHz system clock.
*/
`ifndef SSLC_CFG_SVH
`define SSLC_CFG_SVH
`define SSLC_CLK_MHZ          25
`define SSLC_SETTLE_US        150
`define SSLC_SETTLE_CYC       (`SSLC_SETTLE_US * `SSLC_CLK_MHZ)
`define SSLC_SLOW_WAKE_US     150
`define SSLC_SLOW_WAKE_CYC    (`SSLC_SLOW_WAKE_US * `SSLC_CLK_MHZ)
`define SSLC_FAST_WAKE_CYC    13'h0001
`define SSLC_CNT_W            13
`endif

// >>> verilog/sslc_pkg.sv
/*
  Types for the supply supervisor low-power control block.
  Assumes sslc_cfg.svh supplies the numeric constants.
*/
package sslc_pkg;
  typedef enum logic [1:0] {SSLC_OFF, SSLC_NORMAL, SSLC_FULL} sslc_sup_mode_e;

  typedef struct packed {
    logic core_sup_enable;
    logic core_sup_lpm_keep;
    logic core_sup_full_perf;
    logic core_mon_enable;
    logic core_mon_full_perf;
    logic core_auto_ctrl;
  } sslc_core_ctrl_s;

  typedef struct packed {
    logic io_sup_enable;
    logic io_sup_lpm_keep;
    logic io_sup_full_perf;
    logic io_mon_enable;
    logic io_mon_full_perf;
    logic io_auto_ctrl;
    logic io_overvolt_enable;
  } sslc_io_ctrl_s;

  typedef struct packed {
    sslc_sup_mode_e core_sup;
    sslc_sup_mode_e core_mon;
    sslc_sup_mode_e io_sup;
    sslc_sup_mode_e io_mon;
  } sslc_modes_s;
endpackage

// >>> verilog/sslc_settle_timer.sv
/*
  Settling timer: raises pending on start, clears after a fixed count.
  Assumes start is a one-cycle pulse on clk_sys.
*/
`timescale 1ns/1ps
`include "sslc_cfg.svh"
module sslc_settle_timer
(
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic start,
  output logic      pending
);
  logic [`SSLC_CNT_W-1:0] count;

  // A new write restarts the full settling time
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      count   <= '0;
      pending <= 1'b0;
    end
    else if (start)
    begin
      count   <= `SSLC_CNT_W'(`SSLC_SETTLE_CYC - 1);
      pending <= 1'b1;
    end
    else if (count != '0)
      count <= count - `SSLC_CNT_W'(1);
    else
      pending <= 1'b0;
  end
endmodule

// >>> verilog/sslc_top.sv
/*
  Supply supervisor and monitor low-power control for a power manager.
  Decodes control bits to per-mode supervisor states, selects wake-up
  speed, tracks settling, and routes supervisor events to reset or
  interrupt. Assumes all inputs are synchronous to clk_sys except the
  analog event inputs, which are synchronised here.
*/
`timescale 1ns/1ps
`include "sslc_cfg.svh"

// Functional notes
// - Control write raises settle flag until settled
// - Sleep entry by request or automatically
// - Core off/full-perf gives fast wake-up
// - Core normal-perf enabled forces slow wake-up
// - IO keep clear turns off in sleep
// - IO auto control disables monitor in sleep
// - Overvoltage trip raises power-on reset
// - Core event routes to reset or interrupt
// - Soft power-up clear restores normal operation
module sslc_top
(
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  input  wire logic                   soft_power_up_clear,
  input  sslc_pkg::sslc_core_ctrl_s   core_ctrl_wdata,
  input  wire logic                   core_ctrl_we,
  input  sslc_pkg::sslc_io_ctrl_s     io_ctrl_wdata,
  input  wire logic                   io_ctrl_we,
  input  wire logic                   event_reset_select,
  input  wire logic                   sleep_request,
  input  wire logic                   sleep_on_exit,
  input  wire logic                   isr_return,
  input  wire logic                   wake_request,
  input  wire logic                   core_event_raw,
  input  wire logic                   io_trip_raw,
  output sslc_pkg::sslc_core_ctrl_s   core_supervision_ctrl,
  output sslc_pkg::sslc_io_ctrl_s     io_supervision_ctrl,
  output logic                        core_settle_pending,
  output logic                        io_settle_pending,
  output logic                        deep_sleep,
  output logic                        waking,
  output logic                        slow_wake,
  output sslc_pkg::sslc_modes_s       modes,
  output logic                        power_on_reset,
  output logic                        supply_irq
);
  typedef enum logic [1:0] {SSLC_ACTIVE, SSLC_SLEEP, SSLC_WAKE} sslc_pwr_e;

  sslc_pwr_e              pwr_state;
  logic [`SSLC_CNT_W-1:0] wake_count;
  logic                   rst_any;
  logic [1:0]             core_evt_sync;
  logic [1:0]             io_trip_sync;
  logic                   core_event;
  logic                   io_trip;
  logic                   sleep_entry;
  logic                   next_slow_wake;
  sslc_pkg::sslc_modes_s  next_modes;

  // Supervisor state for active or sleep, one table for all four units
  function automatic sslc_pkg::sslc_sup_mode_e sup_mode(input logic en,
                                                        input logic keep,
                                                        input logic fp,
                                                        input logic auto_c,
                                                        input logic sleep);
    sslc_pkg::sslc_sup_mode_e m;
    m = sslc_pkg::SSLC_OFF;
    if (en && !sleep)
      m = fp ? sslc_pkg::SSLC_FULL : sslc_pkg::SSLC_NORMAL;
    else if (en && keep && !auto_c)
      m = fp ? sslc_pkg::SSLC_FULL : sslc_pkg::SSLC_NORMAL;
    else if (en && keep && auto_c && fp)
      m = sslc_pkg::SSLC_NORMAL;
    return m;
  endfunction

  // Soft clear resets the manager like srst, except the event synchronisers and power_on_reset
  assign rst_any = srst | soft_power_up_clear;

  // ==========================================================
  // Control registers and settling
  always_ff @(posedge clk_sys)
  begin
    if (rst_any)
      core_supervision_ctrl <= '0;
    else if (core_ctrl_we)
      core_supervision_ctrl <= core_ctrl_wdata;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst_any)
      io_supervision_ctrl <= '0;
    else if (io_ctrl_we)
      io_supervision_ctrl <= io_ctrl_wdata;
  end

  sslc_settle_timer u_core_settle
  (
    .clk_sys (clk_sys),
    .srst    (rst_any),
    .start   (core_ctrl_we),
    .pending (core_settle_pending)
  );

  sslc_settle_timer u_io_settle
  (
    .clk_sys (clk_sys),
    .srst    (rst_any),
    .start   (io_ctrl_we),
    .pending (io_settle_pending)
  );

  // ==========================================================
  // Power mode sequencing
  // Software waiting for settling is its own duty; no lockout here
  assign sleep_entry = sleep_request | (isr_return & sleep_on_exit);

  always_comb
  begin
    next_slow_wake = (core_supervision_ctrl.core_sup_enable
                      && !core_supervision_ctrl.core_sup_full_perf)
                  || (core_supervision_ctrl.core_mon_enable
                      && !core_supervision_ctrl.core_mon_full_perf);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst_any)
      slow_wake <= 1'b0;
    else
      slow_wake <= next_slow_wake;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst_any)
    begin
      pwr_state  <= SSLC_ACTIVE;
      wake_count <= '0;
    end
    else
    begin
      unique case (pwr_state)
        SSLC_ACTIVE:
          if (sleep_entry)
            pwr_state <= SSLC_SLEEP;
        SSLC_SLEEP:
          if (wake_request)
          begin
            pwr_state  <= SSLC_WAKE;
            wake_count <= slow_wake ? `SSLC_CNT_W'(`SSLC_SLOW_WAKE_CYC - 1)
                                    : `SSLC_FAST_WAKE_CYC;
          end
        SSLC_WAKE:
          if (wake_count == '0)
            pwr_state <= SSLC_ACTIVE;
          else
            wake_count <= wake_count - `SSLC_CNT_W'(1);
        default:
          pwr_state <= SSLC_ACTIVE;
      endcase
    end
  end

  assign deep_sleep = (pwr_state == SSLC_SLEEP);
  assign waking     = (pwr_state == SSLC_WAKE);

  // ==========================================================
  // Supervisor states
  always_comb
  begin
    next_modes.core_sup = sup_mode(core_supervision_ctrl.core_sup_enable,
                                   core_supervision_ctrl.core_sup_lpm_keep,
                                   core_supervision_ctrl.core_sup_full_perf,
                                   core_supervision_ctrl.core_auto_ctrl,
                                   deep_sleep);
    // Monitor has no keep bit: it always holds unless auto control
    next_modes.core_mon = sup_mode(core_supervision_ctrl.core_mon_enable,
                                   1'b1,
                                   core_supervision_ctrl.core_mon_full_perf,
                                   core_supervision_ctrl.core_auto_ctrl,
                                   deep_sleep);
    next_modes.io_sup   = sup_mode(io_supervision_ctrl.io_sup_enable,
                                   io_supervision_ctrl.io_sup_lpm_keep,
                                   io_supervision_ctrl.io_sup_full_perf,
                                   io_supervision_ctrl.io_auto_ctrl,
                                   deep_sleep);
    next_modes.io_mon   = sup_mode(io_supervision_ctrl.io_mon_enable,
                                   1'b1,
                                   io_supervision_ctrl.io_mon_full_perf,
                                   io_supervision_ctrl.io_auto_ctrl,
                                   deep_sleep);
    if (deep_sleep && io_supervision_ctrl.io_auto_ctrl)
      next_modes.io_mon = sslc_pkg::SSLC_OFF;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst_any)
      modes <= '0;
    else
      modes <= next_modes;
  end

  // ==========================================================
  // Event routing
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      core_evt_sync <= '0;
      io_trip_sync  <= '0;
    end
    else
    begin
      core_evt_sync <= {core_evt_sync[0], core_event_raw};
      io_trip_sync  <= {io_trip_sync[0], io_trip_raw};
    end
  end

  // Events only count while the unit is actually on
  assign core_event = core_evt_sync[1]
                   && ((modes.core_sup != sslc_pkg::SSLC_OFF)
                       || (modes.core_mon != sslc_pkg::SSLC_OFF));
  assign io_trip    = io_trip_sync[1] && (modes.io_mon != sslc_pkg::SSLC_OFF)
                   && io_supervision_ctrl.io_overvolt_enable;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      power_on_reset <= 1'b0;
    else
      power_on_reset <= io_trip
                     || (core_event && event_reset_select);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst_any)
      supply_irq <= 1'b0;
    else
      supply_irq <= core_event && !event_reset_select;
  end
endmodule

// >>> tb/sslc_top_chk.sv
/* Checker for sslc_top: settling, sleep entry, wake speed, sleep modes.
   Assumes binding to sslc_top, one clk_sys domain. */
`timescale 1ns/1ps
module sslc_chk
(
  input wire logic                clk_sys,
  input wire logic                srst,
  input wire logic                soft_power_up_clear,
  input wire logic                core_ctrl_we,
  input wire logic                io_ctrl_we,
  input wire logic                sleep_request,
  input wire logic                sleep_on_exit,
  input wire logic                isr_return,
  input wire logic                wake_request,
  input sslc_pkg::sslc_core_ctrl_s core_supervision_ctrl,
  input sslc_pkg::sslc_io_ctrl_s  io_supervision_ctrl,
  input wire logic                core_settle_pending,
  input wire logic                io_settle_pending,
  input wire logic                deep_sleep,
  input wire logic                waking,
  input wire logic                slow_wake,
  input sslc_pkg::sslc_modes_s    modes
);
  sslc_pkg::sslc_core_ctrl_s prev_core;

  // Wake speed flag is registered, so it trails the control word by a cycle
  always_ff @(posedge clk_sys)
  begin
    if (srst || soft_power_up_clear)
      prev_core <= '0;
    else
      prev_core <= core_supervision_ctrl;
  end

  // ==========================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst || soft_power_up_clear);
  a_core_settle_set: assert property (core_ctrl_we |=> core_settle_pending)
    else $error("core settle flag not raised");
  a_io_settle_set: assert property (io_ctrl_we |=> io_settle_pending)
    else $error("io settle flag not raised");
  a_settle_hold: assert property ($rose(core_settle_pending) |-> core_settle_pending[*8])
    else $error("core settle flag dropped early");
  a_req_entry: assert property (sleep_request && !deep_sleep && !waking |=> deep_sleep)
    else $error("requested sleep not entered");
  a_auto_entry: assert property (isr_return && sleep_on_exit && !deep_sleep && !waking
    |=> deep_sleep)
    else $error("automatic sleep not entered");
  a_wake_speed: assert property (slow_wake == ((prev_core.core_sup_enable &&
    !prev_core.core_sup_full_perf) || (prev_core.core_mon_enable &&
    !prev_core.core_mon_full_perf)))
    else $error("wake speed decode wrong");
  a_fast_wake: assert property (deep_sleep && wake_request && !slow_wake
    |=> waking ##[1:3] !waking)
    else $error("fast wake too long");
  a_io_keep_off: assert property (deep_sleep && io_supervision_ctrl.io_sup_enable &&
    !io_supervision_ctrl.io_sup_lpm_keep |=> modes.io_sup == sslc_pkg::SSLC_OFF)
    else $error("io supervisor not off in sleep");
  a_io_mon_auto: assert property (deep_sleep && io_supervision_ctrl.io_auto_ctrl
    |=> modes.io_mon == sslc_pkg::SSLC_OFF)
    else $error("io monitor active in sleep");
endmodule
bind sslc_top sslc_chk chk_u (.clk_sys, .srst, .soft_power_up_clear, .core_ctrl_we,
  .io_ctrl_we, .sleep_request, .sleep_on_exit, .isr_return, .wake_request,
  .core_supervision_ctrl, .io_supervision_ctrl, .core_settle_pending, .io_settle_pending,
  .deep_sleep, .waking, .slow_wake, .modes);

// >>> tb/tb.sv
/* Random self-checking bench for sslc_top.
   Assumes 3750-cycle settle and slow wake at 25 MHz. */
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0, srst = 1'b1, soft_power_up_clear = 1'b0;
  logic core_ctrl_we = 1'b0, io_ctrl_we = 1'b0, event_reset_select = 1'b0;
  logic sleep_request = 1'b0, sleep_on_exit = 1'b0, isr_return = 1'b0;
  logic wake_request = 1'b0, core_event_raw = 1'b0, io_trip_raw = 1'b0;
  logic core_settle_pending, io_settle_pending, deep_sleep, waking, slow_wake, sl;
  logic power_on_reset, supply_irq;
  sslc_pkg::sslc_core_ctrl_s core_ctrl_wdata = '0, core_supervision_ctrl, c;
  sslc_pkg::sslc_io_ctrl_s   io_ctrl_wdata = '0, io_supervision_ctrl, io;
  sslc_pkg::sslc_modes_s     modes;
  int                        error_cnt = 0, checks = 0, n;
  logic [31:0]               seed = 32'h5E75B0CC;
  always #20 clk_sys = ~clk_sys;
  sslc_top dut_u (.clk_sys, .srst, .soft_power_up_clear, .core_ctrl_wdata, .core_ctrl_we,
    .io_ctrl_wdata, .io_ctrl_we, .event_reset_select, .sleep_request, .sleep_on_exit,
    .isr_return, .wake_request, .core_event_raw, .io_trip_raw, .core_supervision_ctrl,
    .io_supervision_ctrl, .core_settle_pending, .io_settle_pending, .deep_sleep, .waking,
    .slow_wake, .modes, .power_on_reset, .supply_irq);
  // ==========================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [1:0] md(input logic en, kp, fp, au, sl);
    if (!en) return 2'h0;
    if (!sl) return fp ? 2'h2 : 2'h1;
    if (au) return (kp && fp) ? 2'h1 : 2'h0;
    return kp ? (fp ? 2'h2 : 2'h1) : 2'h0;
  endfunction
  // Monitors hold in sleep unless automatic control is on
  function automatic logic [7:0] em(input logic s);
    return {md(c.core_sup_enable, c.core_sup_lpm_keep, c.core_sup_full_perf, c.core_auto_ctrl, s),
      md(c.core_mon_enable, 1'b1, c.core_mon_full_perf, c.core_auto_ctrl, s),
      md(io.io_sup_enable, io.io_sup_lpm_keep, io.io_sup_full_perf, io.io_auto_ctrl, s),
      (s && io.io_auto_ctrl) ? 2'h0 : md(io.io_mon_enable, 1'b1, io.io_mon_full_perf, 1'b0, s)};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tk(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask
  task automatic close_out;
    if (error_cnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================
  // Sequence
  initial
  begin
    #3200000;
    error_cnt++;
    close_out();
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    srst = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      c = (i == 0) ? '0 : (i == 1) ? '1 : seed[5:0];
      io = (i == 1) ? '1 : seed[12:6];
      @(negedge clk_sys);
      core_ctrl_wdata = c;
      io_ctrl_wdata = io;
      core_ctrl_we = 1'b1;
      io_ctrl_we = 1'b1;
      @(negedge clk_sys);
      core_ctrl_we = 1'b0;
      io_ctrl_we = 1'b0;
      tk(1);
      sl = (c.core_sup_enable && !c.core_sup_full_perf) ||
        (c.core_mon_enable && !c.core_mon_full_perf);
      chk("readback", {c, io}, {core_supervision_ctrl, io_supervision_ctrl});
      chk("pending", 2'h3, {core_settle_pending, io_settle_pending});
      chk("slow_wake", sl, slow_wake);
      chk("modes_act", em(1'b0), modes);
      n = 0;
      while ((core_settle_pending || io_settle_pending) && n < 5000)
      begin
        n++;
        tk(1);
      end
      chk("settle_cyc", 16'd3749, n[15:0]);
      @(negedge clk_sys);
      sleep_on_exit = i[0];
      if (i[0]) pulse(isr_return);
      else pulse(sleep_request);
      tk(1);
      chk("deep_sleep", 1'b1, deep_sleep);
      tk(1);
      chk("modes_slp", em(1'b1), modes);
      // Counting starts mid-cycle, right after the wake edge
      pulse(wake_request);
      n = 0;
      while (waking && n < 5000)
      begin
        n++;
        tk(1);
      end
      chk("wake_cyc", sl ? 16'd3750 : 16'd2, n[15:0]);
      @(negedge clk_sys);
      event_reset_select = seed[13];
      core_event_raw = seed[14];
      io_trip_raw = seed[15];
      tk(4);
      // Core events count only while a core unit is on
      chk("por", (seed[13] && seed[14] && (c.core_sup_enable || c.core_mon_enable)) ||
        (seed[15] && io.io_overvolt_enable && io.io_mon_enable), power_on_reset);
      chk("irq", !seed[13] && seed[14] && (c.core_sup_enable || c.core_mon_enable),
        supply_irq);
      @(negedge clk_sys);
      core_event_raw = 1'b0;
      io_trip_raw = 1'b0;
      tk(4);
    end
    pulse(sleep_request);
    tk(2);
    pulse(soft_power_up_clear);
    tk(1);
    chk("clear", 16'h0, {deep_sleep, waking, core_supervision_ctrl, modes});
    close_out();
  end
endmodule
